// ==== rtl/dev_info_status.sv ====
// Device information status register with its event capture and read path.
// Assumes an SPI frame decoder on sys_clk hands over decoded commands, and
// device events arrive as one-cycle pulses on sys_clk; the software
// development strap is a pin and is synchronised here.
`timescale 1ns/100ps
`include "dev_info_defs.svh"
module dev_info_status (
    // Clock and power-on reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // Decoded SPI command from the frame decoder
    input  wire logic                      cmd_valid,
    input  wire dev_info_pkg::reg_addr_t   cmd_addr,
    input  wire logic                      cmd_clear,
    input  wire logic                      cmd_crc_ok,
    input  wire logic                      cmd_crc_static_seq,
    input  wire logic                      cmd_invalid,
    // Device-level reset events
    input  wire logic                      soft_rst_evt,
    input  wire logic                      restart_evt,
    // Device state and events
    input  wire logic                      crc_enabled,
    input  wire logic                      dev_mode_pin,
    input  wire logic                      prior_fail_evt,
    input  wire logic                      prior_sleep_evt,
    input  wire logic                      watchdog_fail_evt,
    input  wire logic                      wd_count_clr_evt,
    input  wire logic                      failure_evt,
    // Read answer
    output logic                           rd_valid_r,
    output dev_info_pkg::reg_word_t        rd_data_r,
    // Status levels for the device
    output logic                           failure_r,
    output logic                           spi_fail_r
);
    import dev_info_pkg::*;

    // ============================================================
    // Storage
    logic                  crc_fail_r;
    prior_code_t           prior_state_code_r;
    wd_count_t             watchdog_failure_count_r;
    logic                  software_development_mode_flag;
    logic                  crc_stat_r;
    logic                  hit;
    logic                  clear_hit;
    logic                  crc_fail_set;
    reg_word_t             status_word;

    // ============================================================
    // Strap synchroniser
    level_sync3 #(
        .WIDTH    (1)
    ) u_swdev_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (dev_mode_pin),
        .sync_out (software_development_mode_flag)
    );

    // ============================================================
    // Command decode
    // Read of this register is answered whatever the CRC field; a bad CRC still sets the CRC failure flag
    assign hit          = cmd_valid && (cmd_addr == `DIS_ADDR);
    // Clear needs a valid frame when CRC is on, so a corrupt frame cannot wipe flags
    assign clear_hit    = hit && cmd_clear && (cmd_crc_ok || !crc_enabled);
    // Static enable/disable sequence never counts as a CRC failure
    assign crc_fail_set = cmd_valid && crc_enabled && !cmd_crc_ok
                          && !cmd_crc_static_seq;

    // Assembled word; reserved bits tied to zero
    always_comb begin
        status_word                                   = `DIS_RESET_VALUE;
        status_word[`DIS_CRC_STAT_BIT]                = crc_stat_r;
        status_word[`DIS_CRC_FAIL_BIT]                = crc_fail_r;
        status_word[`DIS_PRIOR_HI:`DIS_PRIOR_LO]      = prior_state_code_r;
        status_word[`DIS_SWDEV_BIT]                   = software_development_mode_flag;
        status_word[`DIS_WDCNT_HI:`DIS_WDCNT_LO]      = watchdog_failure_count_r;
        status_word[`DIS_SPI_FAIL_BIT]                = spi_fail_r;
        status_word[`DIS_FAILURE_BIT]                 = failure_r;
    end

    // ============================================================
    // CRC enable mirror
    always_ff @(posedge sys_clk) begin
        if (rst || soft_rst_evt) begin
            crc_stat_r <= 1'b0;
        end else begin
            crc_stat_r <= crc_enabled;
        end
    end

    // CRC failure flag; a new failure beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst || soft_rst_evt) begin
            crc_fail_r <= 1'b0;
        end else if (crc_fail_set) begin
            crc_fail_r <= 1'b1;
        end else if (clear_hit) begin
            crc_fail_r <= 1'b0;
        end
    end

    // ============================================================
    // Prior state code; kept over restart, only a host clear or a reset clears it
    always_ff @(posedge sys_clk) begin
        if (rst || soft_rst_evt) begin
            prior_state_code_r <= PRIOR_CLEARED;
        end else if (prior_fail_evt) begin
            prior_state_code_r <= PRIOR_RESTART;
        end else if (prior_sleep_evt) begin
            prior_state_code_r <= PRIOR_SLEEP;
        end else if (clear_hit) begin
            prior_state_code_r <= PRIOR_CLEARED;
        end
    end

    // ============================================================
    // Watchdog failure counter, saturating; device clears it itself
    always_ff @(posedge sys_clk) begin
        if (rst || soft_rst_evt) begin
            watchdog_failure_count_r <= `DIS_WDCNT_ZERO;
        end else if (watchdog_fail_evt) begin
            if (watchdog_failure_count_r != `DIS_WDCNT_MAX) begin
                watchdog_failure_count_r <= watchdog_failure_count_r + 2'h1;
            end
        end else if (wd_count_clr_evt) begin
            watchdog_failure_count_r <= `DIS_WDCNT_ZERO;
        end
    end

    // ============================================================
    // Invalid command flag; of the internal events only soft reset touches it
    always_ff @(posedge sys_clk) begin
        if (rst || soft_rst_evt) begin
            spi_fail_r <= 1'b0;
        end else if (cmd_invalid) begin
            spi_fail_r <= 1'b1;
        end else if (clear_hit) begin
            spi_fail_r <= 1'b0;
        end
    end

    // Failure flag, sticky until host clear
    always_ff @(posedge sys_clk) begin
        if (rst || soft_rst_evt) begin
            failure_r <= 1'b0;
        end else if (failure_evt) begin
            failure_r <= 1'b1;
        end else if (clear_hit) begin
            failure_r <= 1'b0;
        end
    end

    // ============================================================
    // Read path; restart needs no action since every kept bit is held
    // and every reserved bit is constant zero
    always_ff @(posedge sys_clk) begin
        if (rst || soft_rst_evt) begin
            rd_valid_r <= 1'b0;
            rd_data_r  <= `DIS_RESET_VALUE;
        end else begin
            rd_valid_r <= hit && !cmd_clear;
            if (hit) begin
                rd_data_r <= status_word & `DIS_KEEP_MASK;
            end
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence bad_frame_s;
        cmd_valid && crc_enabled && !cmd_crc_ok && !cmd_crc_static_seq && !soft_rst_evt;
    endsequence

    sequence read_req_s;
        cmd_valid && (cmd_addr == `DIS_ADDR) && !cmd_clear && !soft_rst_evt;
    endsequence

    reserved_zero_a: assert property (
        rd_valid_r |-> (rd_data_r[15:10] == 6'h00) && !rd_data_r[5])
        else $error("reserved status bits read nonzero");

    bad_read_served_a: assert property (
        read_req_s |=> rd_valid_r && (rd_data_r[9] == $past(crc_stat_r)))
        else $error("status read not served");

    crc_fail_set_a: assert property (bad_frame_s |=> crc_fail_r)
        else $error("crc failure not flagged");

    static_seq_a: assert property (
        (!crc_fail_r && cmd_valid && cmd_crc_static_seq && !cmd_crc_ok)
        |=> !crc_fail_r)
        else $error("static crc sequence flagged as failure");

    prior_fail_a: assert property (
        (prior_fail_evt && !soft_rst_evt) |=> prior_state_code_r == PRIOR_RESTART)
        else $error("failure restart code missing");

    prior_sleep_a: assert property (
        (prior_sleep_evt && !prior_fail_evt && !soft_rst_evt)
        |=> prior_state_code_r == PRIOR_SLEEP)
        else $error("sleep code missing");

    prior_hold_a: assert property (
        (!clear_hit && !prior_fail_evt && !prior_sleep_evt && !soft_rst_evt)
        |=> $stable(prior_state_code_r))
        else $error("prior state changed without cause");

    wd_saturate_a: assert property (
        (watchdog_failure_count_r == `DIS_WDCNT_MAX && watchdog_fail_evt && !soft_rst_evt)
        |=> watchdog_failure_count_r == `DIS_WDCNT_MAX)
        else $error("watchdog count left saturation");

    wd_step_a: assert property (
        (watchdog_fail_evt && !soft_rst_evt && watchdog_failure_count_r != `DIS_WDCNT_MAX)
        |=> watchdog_failure_count_r == $past(watchdog_failure_count_r) + 2'h1)
        else $error("watchdog count did not step");

    spi_fail_sticky_a: assert property (
        (spi_fail_r && !clear_hit && !soft_rst_evt) |=> spi_fail_r)
        else $error("invalid command flag lost");

    failure_set_a: assert property (
        (failure_evt && !soft_rst_evt) |=> failure_r ##1 (failure_r || $past(clear_hit)))
        else $error("failure flag not held");

    soft_reset_a: assert property (
        soft_rst_evt |=> !failure_r && !spi_fail_r && !crc_fail_r
                         && prior_state_code_r == PRIOR_CLEARED
                         && watchdog_failure_count_r == `DIS_WDCNT_ZERO)
        else $error("soft reset left status bits");

    restart_keep_a: assert property (
        (restart_evt && !soft_rst_evt && !failure_evt && !cmd_valid)
        |=> $stable(failure_r) && $stable(spi_fail_r))
        else $error("restart disturbed kept bits");

    read_keeps_a: assert property (
        (read_req_s and (failure_r && !failure_evt)) |=> failure_r)
        else $error("read cleared a flag");

    // ============================================================
    // Host clear steps: a good clear wipes the clear-type flags, a refused
    // one only adds the CRC failure, and neither produces a read answer
    sequence good_clear_s;
        clear_hit && !soft_rst_evt;
    endsequence

    sequence refused_clear_s;
        cmd_valid && (cmd_addr == `DIS_ADDR) && cmd_clear && crc_enabled && !cmd_crc_ok
        && !cmd_crc_static_seq && !soft_rst_evt;
    endsequence

    clear_flags_a: assert property (
        (good_clear_s and (!cmd_invalid && !failure_evt && !prior_fail_evt && !prior_sleep_evt))
        |=> !crc_fail_r && !spi_fail_r && !failure_r && prior_state_code_r == PRIOR_CLEARED)
        else $error("host clear left a flag set");

    refused_clear_a: assert property (
        (refused_clear_s and failure_r) |=> failure_r && crc_fail_r)
        else $error("refused clear changed flags");

    clear_silent_a: assert property (
        (cmd_valid && (cmd_addr == `DIS_ADDR) && cmd_clear && !soft_rst_evt) |=> !rd_valid_r)
        else $error("clear produced a read answer");

    // ============================================================
    // Watchdog counter: kept over a host clear, emptied by the device
    wd_clear_keep_a: assert property (
        (good_clear_s and (!watchdog_fail_evt && !wd_count_clr_evt))
        |=> $stable(watchdog_failure_count_r))
        else $error("host clear touched the watchdog count");

    wd_self_clear_a: assert property (
        (wd_count_clr_evt && !watchdog_fail_evt && !soft_rst_evt)
        |=> watchdog_failure_count_r == `DIS_WDCNT_ZERO)
        else $error("watchdog count not emptied");

    // ============================================================
    // Set events, mirrors and the read path after a soft reset
    spi_fail_set_a: assert property ((cmd_invalid && !soft_rst_evt) |=> spi_fail_r)
        else $error("invalid command not flagged");

    crc_stat_track_a: assert property (
        !soft_rst_evt |=> crc_stat_r == $past(crc_enabled))
        else $error("crc enable not mirrored");

    prior_code_legal_a: assert property (
        rd_valid_r |-> rd_data_r[`DIS_PRIOR_HI:`DIS_PRIOR_LO] != `DIS_PRIOR_RSVD)
        else $error("reserved prior state code read");

    swdev_rise_a: assert property (
        dev_mode_pin [*4] |=> software_development_mode_flag)
        else $error("development mode not shown");

    swdev_fall_a: assert property (
        (!dev_mode_pin) [*4] |=> !software_development_mode_flag)
        else $error("development mode not withdrawn");

    soft_read_a: assert property (
        soft_rst_evt |=> !rd_valid_r && rd_data_r == `DIS_RESET_VALUE)
        else $error("soft reset left a read answer");
endmodule : dev_info_status

// ==== rtl/dev_info_defs.svh ====
// Constants of the device information status register: offset, fields, resets.
// Included by bare name wherever the macros are used; the guard allows repeats.
//
// Summary of operation
// - Bits 15:10 and bit 5 always read as zero.
// - Bit 9 shows whether frame CRC checking is enabled.
// - A read of this register is served even with a bad CRC.
// - Bit 8 sets on a CRC failure, not on the static CRC sequence.
// - Bits 7:6 hold prior state: 00 cleared, 01 failure, 10 sleep.
// - Failure restarts and wakes from fail-safe set prior state code 01.
// - Sleep entry with uncleared wake flags sets the sleep code.
// - Bit 4 shows software development mode, updated by hardware.
// - Bits 3:2 count watchdog failures, saturating at three.
// - Only the watchdog counter clears itself; other flags wait for host.
// - Bit 1 sets when an invalid SPI command arrives.
// - The invalid command flag clears only by host SPI command or by reset.
// - Bit 0 sets on a detected failure and stays until cleared.
// - Power-on reset zeroes all sixteen bits; soft reset zeroes all but bit 4.
// - Restart zeroes 15:10 and 5, keeps all other bits.
`ifndef DEV_INFO_DEFS_SVH
`define DEV_INFO_DEFS_SVH

// ============================================================
// Address and widths
`define DIS_ADDR_W        7
`define DIS_ADDR          7'h42
`define DIS_DATA_W        16

// ============================================================
// Field positions
`define DIS_CRC_STAT_BIT  9
`define DIS_CRC_FAIL_BIT  8
`define DIS_PRIOR_HI      7
`define DIS_PRIOR_LO      6
`define DIS_SWDEV_BIT     4
`define DIS_WDCNT_HI      3
`define DIS_WDCNT_LO      2
`define DIS_SPI_FAIL_BIT  1
`define DIS_FAILURE_BIT   0

// ============================================================
// Codes and reset values
`define DIS_PRIOR_CLEARED 2'h0
`define DIS_PRIOR_RESTART 2'h1
`define DIS_PRIOR_SLEEP   2'h2
`define DIS_PRIOR_RSVD    2'h3
`define DIS_WDCNT_ZERO    2'h0
`define DIS_WDCNT_MAX     2'h3
`define DIS_RESET_VALUE   16'h0000
`define DIS_KEEP_MASK     16'h03df

`endif

// ==== rtl/dev_info_pkg.sv ====
// Types of the device information status register.
// Assumes the constants header sits beside it in rtl/.
`include "dev_info_defs.svh"
package dev_info_pkg;
    typedef logic [`DIS_ADDR_W-1:0] reg_addr_t;
    typedef logic [`DIS_DATA_W-1:0] reg_word_t;
    typedef logic [1:0]             wd_count_t;
    typedef enum logic [1:0] {
        PRIOR_CLEARED = `DIS_PRIOR_CLEARED,
        PRIOR_RESTART = `DIS_PRIOR_RESTART,
        PRIOR_SLEEP   = `DIS_PRIOR_SLEEP,
        PRIOR_RSVD    = `DIS_PRIOR_RSVD
    } prior_code_t;
endpackage : dev_info_pkg

// ==== rtl/level_sync3.sv ====
// Three-stage level synchroniser with agreement filter.
// Assumes the input is asynchronous to sys_clk; output changes only when
// the second and third stages agree.
`timescale 1ns/100ps
module level_sync3 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Level in and filtered level out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    // Refuse widths the per-bit filter cannot serve
    if (WIDTH < 1) begin : g_bad_width
        $error("level_sync3 needs WIDTH of at least 1");
    end

    // Stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_r   <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end else begin
            meta_r   <= async_in;
            stage2_r <= meta_r;
            stage3_r <= stage2_r;
        end
    end

    // Accept a new level only once two stages agree, per bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync_out <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_r[i] == stage3_r[i]) begin
                    sync_out[i] <= stage3_r[i];
                end
            end
        end
    end
endmodule : level_sync3

// ==== tb/spi_host_model.sv ====
// Host side of the decoded SPI command port of the status register.
// Assumes the testbench calls access() and that commands start off a negedge.
`timescale 1ns/100ps
module spi_host_model (
    // Clock
    input  wire logic                    sys_clk,
    // Read answer from the register
    input  wire logic                    rd_valid_r,
    input  wire dev_info_pkg::reg_word_t rd_data_r,
    // Decoded command towards the register
    output logic                         cmd_valid,
    output dev_info_pkg::reg_addr_t      cmd_addr,
    output logic                         cmd_clear,
    output logic                         cmd_crc_ok,
    output logic                         cmd_crc_static_seq
);
    import dev_info_pkg::*;

    // ============================================================
    // Idle command lines at time zero
    initial begin
        cmd_valid          = 1'b0;
        cmd_addr           = 7'h00;
        cmd_clear          = 1'b0;
        cmd_crc_ok         = 1'b1;
        cmd_crc_static_seq = 1'b0;
    end

    // ============================================================
    // One frame: drive at negedge, hold over the taking edge, then wait
    // a bounded time for the answer; the prior field is cleared by an
    // explicit clear frame from here or by a soft or power-on reset
    task automatic access(input reg_addr_t a, input logic clr, input logic ok,
                          input logic seq, output logic got, output reg_word_t d);
        int n;
        n = 0;
        got = 1'b0;
        d = 16'h0000;
        @(negedge sys_clk);
        cmd_valid          = 1'b1;
        cmd_addr           = a;
        cmd_clear          = clr;
        cmd_crc_ok         = ok;
        cmd_crc_static_seq = seq;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        cmd_addr  = ~a; // Released lines do not keep the old address
        while (n < 3 && !got) begin
            if (rd_valid_r === 1'b1) begin
                got = 1'b1;
                d = rd_data_r;
            end else begin
                @(negedge sys_clk);
                n++;
            end
        end
    endtask : access
endmodule : spi_host_model

// ==== tb/tb_device_info_status_register.sv ====
// Self-checking bench of the device information status register.
// Assumes the host model above and the design under rtl/.
`timescale 1ns/100ps
module tb_device_info_status_register;
    import dev_info_pkg::*;

    localparam int EV_SOFT = 0, EV_RST = 1, EV_PFAIL = 2, EV_PSLP = 3;
    localparam int EV_WD = 4, EV_WDCLR = 5, EV_FAIL = 6, EV_INV = 7;

    logic        sys_clk, rst, crc_enabled, dev_mode_pin;
    logic [7:0]  evt;
    logic        cmd_valid, cmd_clear, cmd_crc_ok, cmd_crc_static_seq;
    reg_addr_t   cmd_addr;
    logic        rd_valid_r, failure_r, spi_fail_r, got;
    reg_word_t   rd_data_r, data;
    int          bad_count, num_checks, cycles;

    // ============================================================
    // Clock, timeout watchdog
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // The whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            test_done();
        end
    end

    spi_host_model host (.sys_clk(sys_clk), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
        .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_clear(cmd_clear),
        .cmd_crc_ok(cmd_crc_ok), .cmd_crc_static_seq(cmd_crc_static_seq));

    dev_info_status DUT (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_addr(cmd_addr), .cmd_clear(cmd_clear), .cmd_crc_ok(cmd_crc_ok),
        .cmd_crc_static_seq(cmd_crc_static_seq), .cmd_invalid(evt[EV_INV]),
        .soft_rst_evt(evt[EV_SOFT]), .restart_evt(evt[EV_RST]),
        .crc_enabled(crc_enabled), .dev_mode_pin(dev_mode_pin),
        .prior_fail_evt(evt[EV_PFAIL]), .prior_sleep_evt(evt[EV_PSLP]),
        .watchdog_fail_evt(evt[EV_WD]), .wd_count_clr_evt(evt[EV_WDCLR]),
        .failure_evt(evt[EV_FAIL]), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
        .failure_r(failure_r), .spi_fail_r(spi_fail_r));

    // ============================================================
    // Helpers: compare, event pulse, read, clear, verdict
    task automatic check(input string what, input reg_word_t seen, input reg_word_t exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One-cycle pulse launched off the falling edge
    task automatic pulse(input int i);
        @(negedge sys_clk);
        evt[i] = 1'b1;
        @(negedge sys_clk);
        evt[i] = 1'b0;
    endtask : pulse

    task automatic rd(input reg_word_t exp);
        host.access(7'h42, 1'b0, 1'b1, 1'b0, got, data);
        check("read answer", {15'h0, got}, 16'h0001);
        check("status word", data, exp);
    endtask : rd

    // A clear gives no read answer
    task automatic clr();
        host.access(7'h42, 1'b1, 1'b1, 1'b0, got, data);
        check("clear answer", {15'h0, got}, 16'h0000);
    endtask : clr

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    // ============================================================
    // Main sequence
    initial begin
        bad_count = 0;
        num_checks = 0;
        cycles = 0;
        rst = 1'b1;
        evt = 8'h00;
        crc_enabled = 1'b0;
        dev_mode_pin = 1'b0;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        check("reset outputs", {14'h0, failure_r, spi_fail_r}, 16'h0000);
        rd(16'h0000);
        crc_enabled = 1'b1;
        @(negedge sys_clk);
        rd(16'h0200);
        // Bad CRC read is still answered, then flags the CRC failure
        host.access(7'h42, 1'b0, 1'b0, 1'b0, got, data);
        check("bad crc read", {15'h0, got}, 16'h0001);
        rd(16'h0300);
        clr();
        rd(16'h0200);
        host.access(7'h10, 1'b0, 1'b0, 1'b1, got, data);
        rd(16'h0200);
        // Clear with bad CRC is refused but counts as CRC failure
        pulse(EV_FAIL);
        host.access(7'h42, 1'b1, 1'b0, 1'b0, got, data);
        rd(16'h0301);
        clr();
        rd(16'h0200);
        pulse(EV_PFAIL);
        rd(16'h0240);
        rd(16'h0240);
        pulse(EV_RST);
        rd(16'h0240);
        clr();
        pulse(EV_PSLP);
        rd(16'h0280);
        clr();
        // Watchdog counter saturates and survives a host clear
        for (int i = 1; i <= 4; i++) begin
            pulse(EV_WD);
            rd(16'h0200 | ((i > 3 ? 16'h0003 : 16'(i)) << 2));
        end
        clr();
        rd(16'h020c);
        pulse(EV_WDCLR);
        rd(16'h0200);
        pulse(EV_INV);
        check("spi fail level", {15'h0, spi_fail_r}, 16'h0001);
        pulse(EV_RST);
        pulse(EV_WDCLR);
        rd(16'h0202);
        pulse(EV_FAIL);
        check("failure level", {15'h0, failure_r}, 16'h0001);
        dev_mode_pin = 1'b1;
        repeat (8) @(negedge sys_clk);
        rd(16'h0213);
        clr();
        rd(16'h0210);
        pulse(EV_FAIL);
        dev_mode_pin = 1'b0;
        crc_enabled = 1'b0;
        repeat (8) @(negedge sys_clk);
        rd(16'h0001);
        pulse(EV_SOFT);
        check("soft reset levels", {14'h0, failure_r, spi_fail_r}, 16'h0000);
        rd(16'h0000);
        test_done();
    end
endmodule : tb_device_info_status_register
